//--- logic/ain_scaling_pkg.sv
// Shared constants for the analog input scaling and routing block.
package ain_scaling_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_RANGE    = 8'h00;
  localparam logic [7:0] OFF_FUNCTION = 8'h04;
  localparam logic [7:0] OFF_GAIN     = 8'h08;
  localparam logic [7:0] OFF_BIAS     = 8'h0C;
  localparam logic [7:0] OFF_FILTER   = 8'h10;
  localparam logic [7:0] OFF_VALUE    = 8'h14;
  // Reset values; percentages are signed tenths of a percent.
  localparam logic [15:0] RST_RANGE    = 16'h0002;
  localparam logic [15:0] RST_FUNCTION = 16'h0000;
  localparam logic [15:0] RST_GAIN     = 16'h03E8;
  localparam logic [15:0] RST_BIAS     = 16'h0000;
  localparam logic [15:0] RST_FILTER   = 16'h0005;
  // Legal setting limits in tenths of a percent and hundredths of a second.
  localparam logic signed [15:0] PCT_MIN    = -16'sd9990;
  localparam logic signed [15:0] PCT_MAX    = 16'sd9999;
  localparam logic signed [15:0] PCT_FULL   = 16'sd1000;
  localparam logic [15:0]        FILTER_MAX = 16'h00C8;
  localparam logic [15:0]        FUNC_MAX   = 16'h0013;
  // Input range codes.
  typedef enum logic [1:0] {
    RANGE_0_20MA = 2'b00,
    RANGE_4_20MA = 2'b01,
    RANGE_0_10V  = 2'b10,
    RANGE_0_5V   = 2'b11
  } range_t;
  // Function codes that carry a meaning.
  localparam logic [4:0] FN_MAIN_FREQ = 5'd0;
  localparam logic [4:0] FN_LOWER_LIM = 5'd2;
  localparam logic [4:0] FN_AUX_FREQ  = 5'd3;
  localparam logic [4:0] FN_VOLT_BIAS = 5'd4;
  localparam logic [4:0] FN_RAMP_GAIN = 5'd5;
  localparam logic [4:0] FN_BRAKE_CUR = 5'd6;
  localparam logic [4:0] FN_STALL_LVL = 5'd7;
  localparam logic [4:0] FN_PID_FB    = 5'd8;
  localparam logic [4:0] FN_PID_TGT   = 5'd9;
  localparam logic [4:0] FN_PID_DIFF  = 5'd10;
  localparam logic [4:0] FN_TORQUE    = 5'd11;
  localparam logic [4:0] FN_HOST_ONE  = 5'd18;
  localparam logic [4:0] FN_HOST_TWO  = 5'd19;
  // Frequency source code that selects the analog input.
  localparam logic [3:0] SRC_ANALOG = 4'h1;
  // Converter code for 4 mA on a 20 mA scale (20 percent of 4096).
  localparam logic [11:0] CODE_4MA = 12'h333;
  // Filter update period and the clock rate.
  localparam int CLK_HZ        = 25_000_000;
  localparam int SAMPLE_US     = 1000;
  localparam int SAMPLE_CYCLES = CLK_HZ / 1_000_000 * SAMPLE_US;
  // Filter time unit (10 ms) expressed in update periods.
  localparam logic [3:0] FILTER_TICKS_PER_UNIT = 4'd10;
endpackage : ain_scaling_pkg

//--- logic/ain_scaling_router.sv
// Analog input scaling, lag filter and function routing with APB registers.
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
// Overview of operation
// RL1: Range codes 0-3, reset to 0-10 V.
// RL2: Voltage ranges clamp negative results to zero.
// RL3: Function code 0 to 19, reset 0.
// RL4: Gain gives percent at full-scale input.
// RL5: Bias gives percent at zero input.
// RL6: Gain, bias -999..999.9 percent; reset 100, 0.
// RL7: Frequency command saturates at 100 percent.
// RL8: 0-20 mA clamps negative; 4-20 mA reverses.
// RL9: Lag filter 0.00-2.00 s, reset 0.05 s.
// RL10: Function codes map to their drive functions.
// RL11: Main frequency only when source selects analog.
// RL12: Ramp gain only shortens programmed accel time.
// RL13: Braking current is min of input, programmed.
// RL14: Stall level is min of input, programmed.
// RL15: PID target overrides command when PID enabled.
// RL16: PID input is feedback minus differential value.
// RL17: Torque level at 100 percent equals rated.
// RL18: Codes 18, 19 make value host readable.
// RL19: Voltage bias scales 200/400 V, V/f only.
// RL20: Lower limit follows the scaled input.
// RL21: Scaled value is bias plus gain times fraction.
// RL22: Recursive filter, zero setting passes samples.
module ain_scaling_router #(
  parameter int SAMPLE_PERIOD = ain_scaling_pkg::SAMPLE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] first_analog_input,
  input  wire logic [3:0]  primary_freq_source_select,
  input  wire logic [3:0]  alternate_freq_source_select,
  input  wire logic [2:0]  pid_enable_select,
  input  wire logic [2:0]  torque_detect_select_one,
  input  wire logic        vf_control_mode,
  input  wire logic        supply_400v,
  input  wire logic [15:0] programmed_braking_current,
  input  wire logic [15:0] run_stall_level,
  input  wire logic [15:0] first_accel_time,
  input  wire logic [15:0] pid_feedback_primary,
  output logic      [19:0] func_active,
  output logic      [15:0] func_value,
  output logic      [15:0] freq_command,
  output logic             freq_reverse,
  output logic      [15:0] lower_freq_limit,
  output logic      [15:0] volt_bias_decivolt,
  output logic      [15:0] accel_time_applied,
  output logic      [15:0] braking_current_applied,
  output logic      [15:0] stall_level_applied,
  output logic      [15:0] pid_input,
  output logic             pid_target_override
);
  import ain_scaling_pkg::*;

  // Software settings.
  logic [1:0]         input_range_select;     // Signal range code.
  logic [4:0]         input_function_select;  // Routing target code.
  logic signed [15:0] input_gain_percent;     // Tenths of a percent.
  logic signed [15:0] input_bias_percent;     // Tenths of a percent.
  logic [7:0]         input_filter_time;      // Hundredths of a second.
  // Filter state and update timing.
  logic signed [15:0] filtered;               // Filter output.
  logic [31:0]        tick_count;             // Update period counter.
  logic               tick;                   // One-cycle update strobe.

  // APB decode: writes complete in the access cycle that shows pready.
  wire        wr_en   = psel & penable & pwrite & pready;
  wire        setup   = psel & ~penable;
  wire [15:0] wdata16 = pwdata[15:0];
  // Word addresses that the block answers; others raise pslverr.
  wire        hit = (paddr == OFF_RANGE) || (paddr == OFF_FUNCTION) ||
                    (paddr == OFF_GAIN) || (paddr == OFF_BIAS) ||
                    (paddr == OFF_FILTER) || (paddr == OFF_VALUE);
  wire signed [15:0] wpct = wdata16;
  // Percent writes are held inside the legal setting span.
  wire signed [15:0] wpct_lim = (wpct < PCT_MIN) ? PCT_MIN :
                                (wpct > PCT_MAX) ? PCT_MAX : wpct; // [RL6]
  wire [15:0] wfilt_lim = (wdata16 > FILTER_MAX) ? FILTER_MAX
                                                 : wdata16; // [RL9]
  // Function codes above the span leave the old code in place.
  wire        wfunc_ok  = (wdata16 <= FUNC_MAX); // [RL3]

  // Read mux; the last word exposes the filtered value to the host.
  wire [15:0] rd16 =
    (paddr == OFF_RANGE)    ? {14'h0000, input_range_select} :
    (paddr == OFF_FUNCTION) ? {11'h000, input_function_select} :
    (paddr == OFF_GAIN)     ? input_gain_percent :
    (paddr == OFF_BIAS)     ? input_bias_percent :
    (paddr == OFF_FILTER)   ? {8'h00, input_filter_time} :
    (paddr == OFF_VALUE)    ? filtered : 16'h0000; // [RL18]

  // Bus handshake: one wait-free access phase after every setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= setup ? {16'h0000, rd16} : 32'h0000_0000;
    end
  end

  // Setting registers; out-of-span function codes are ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_range_select    <= RST_RANGE[1:0]; // [RL1]
      input_function_select <= RST_FUNCTION[4:0]; // [RL3]
      input_gain_percent    <= RST_GAIN; // [RL6]
      input_bias_percent    <= RST_BIAS; // [RL6]
      input_filter_time     <= RST_FILTER[7:0]; // [RL9]
    end else if (wr_en) begin
      if (paddr == OFF_RANGE) begin
        input_range_select <= wdata16[1:0]; // [RL1]
      end
      if (paddr == OFF_FUNCTION && wfunc_ok) begin
        input_function_select <= wdata16[4:0]; // [RL3]
      end
      if (paddr == OFF_GAIN) begin
        input_gain_percent <= wpct_lim; // [RL4]
      end
      if (paddr == OFF_BIAS) begin
        input_bias_percent <= wpct_lim; // [RL5]
      end
      if (paddr == OFF_FILTER) begin
        input_filter_time <= wfilt_lim[7:0];
      end
    end
  end

  // Normalised input fraction, 4096 meaning full scale of the range.
  wire signed [14:0] raw_frac  = $signed({3'b000, first_analog_input});
  wire signed [14:0] live_zero = raw_frac - $signed({3'b000, CODE_4MA});
  // A 4-20 mA signal spans 80 percent of the converter, hence 5/4.
  wire signed [16:0] frac_420  = (17'(live_zero) * 17'sd5) >>> 2;
  wire signed [16:0] frac      =
    (input_range_select == RANGE_4_20MA) ? frac_420 : 17'(raw_frac);
  // Linear scaling: bias plus gain times fraction.
  wire signed [32:0] prod     = 33'(input_gain_percent) * 33'(frac);
  wire signed [20:0] scaled   = 21'(input_bias_percent) +
                                21'(prod >>> 12); // [RL21]
  // Only the 4-20 mA range keeps a negative value, for reversing.
  wire neg_ok = (input_range_select == RANGE_4_20MA); // [RL8]
  wire signed [20:0] floored  = (!neg_ok && scaled < 0) ? 21'sd0
                                                        : scaled; // [RL2]
  wire signed [15:0] sample   =
    (floored > 21'(PCT_MAX)) ? PCT_MAX :
    (floored < 21'(PCT_MIN)) ? PCT_MIN : floored[15:0];

  // Recursive lag step; the divisor is the time constant in updates.
  wire signed [16:0] step_diff = 17'(sample) - 17'(filtered);
  wire signed [12:0] divisor   =
    13'(input_filter_time) * $signed({9'd0, FILTER_TICKS_PER_UNIT});
  // Division truncates toward zero, so the step never overshoots the
  // sample; a small residue stays until the input moves again.
  wire signed [16:0] step      =
    (input_filter_time == 8'h00) ? 17'sd0 : step_diff / 17'(divisor);
  wire signed [15:0] next_filtered =
    (input_filter_time == 8'h00) ? sample
                                 : 16'(17'(filtered) + step); // [RL22]

  // Fixed-rate update strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_count <= 32'h0000_0000;
      tick       <= 1'b0;
    end else begin
      tick       <= (tick_count == 32'(SAMPLE_PERIOD - 1));
      tick_count <= (tick_count == 32'(SAMPLE_PERIOD - 1)) ? 32'h0000_0000
                                                           : tick_count + 1;
    end
  end

  // The filter state advances once per update strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filtered <= 16'sh0000;
    end else if (tick) begin
      filtered <= next_filtered; // [RL9]
    end
  end

  // Routing conditions for each function.
  wire [4:0] fn = input_function_select;
  wire analog_src = (primary_freq_source_select == SRC_ANALOG) ||
                    (alternate_freq_source_select == SRC_ANALOG); // [RL11]
  wire pid_on    = (pid_enable_select != 3'b000);
  wire torque_on = (torque_detect_select_one != 3'b000);
  logic [19:0] next_active;
  // One-hot active flags; reserved codes light nothing.
  always_comb begin
    next_active = 20'h0_0000;
    next_active[FN_MAIN_FREQ] = (fn == FN_MAIN_FREQ) & analog_src; // [RL11]
    next_active[FN_LOWER_LIM] = (fn == FN_LOWER_LIM); // [RL10]
    next_active[FN_AUX_FREQ]  = (fn == FN_AUX_FREQ); // [RL10]
    next_active[FN_VOLT_BIAS] = (fn == FN_VOLT_BIAS) & vf_control_mode;
    next_active[FN_RAMP_GAIN] = (fn == FN_RAMP_GAIN); // [RL10]
    next_active[FN_BRAKE_CUR] = (fn == FN_BRAKE_CUR); // [RL10]
    next_active[FN_STALL_LVL] = (fn == FN_STALL_LVL); // [RL10]
    next_active[FN_PID_FB]    = (fn == FN_PID_FB) & pid_on; // [RL10]
    next_active[FN_PID_TGT]   = (fn == FN_PID_TGT) & pid_on; // [RL15]
    next_active[FN_PID_DIFF]  = (fn == FN_PID_DIFF); // [RL16]
    next_active[FN_TORQUE]    = (fn == FN_TORQUE) & torque_on; // [RL17]
    next_active[FN_HOST_ONE]  = (fn == FN_HOST_ONE); // [RL18]
    next_active[FN_HOST_TWO]  = (fn == FN_HOST_TWO); // [RL18]
  end

  // Derived values for the routed functions.
  wire signed [15:0] pos_val  = (filtered < 0) ? 16'sh0000 : filtered;
  wire signed [15:0] mag_val  = (filtered < 0) ? -filtered : filtered;
  wire [15:0] freq_sat = (mag_val > PCT_FULL) ? PCT_FULL : mag_val; // [RL7]
  wire [15:0] gain_cap = (pos_val > PCT_FULL) ? PCT_FULL : pos_val; // [RL12]
  wire [31:0] ramp_mul = 32'(first_accel_time) * 32'(gain_cap);
  wire [15:0] ramp_val = 16'(ramp_mul / 32'(PCT_FULL));
  wire [15:0] brake_min = (pos_val < programmed_braking_current) ?
                          pos_val : programmed_braking_current; // [RL13]
  wire [15:0] stall_min = (pos_val < run_stall_level) ?
                          pos_val : run_stall_level; // [RL14]
  // Tenths of a percent of 200 V or 400 V, expressed in tenths of a volt.
  wire [15:0] vbias_val = supply_400v ? 16'(pos_val * 4)
                                      : 16'(pos_val * 2); // [RL19]

  // Registered outputs follow the filtered value and routing each cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_active             <= 20'h0_0000;
      func_value              <= 16'h0000;
      freq_command            <= 16'h0000;
      freq_reverse            <= 1'b0;
      lower_freq_limit        <= 16'h0000;
      volt_bias_decivolt      <= 16'h0000;
      accel_time_applied      <= 16'h0000;
      braking_current_applied <= 16'h0000;
      stall_level_applied     <= 16'h0000;
      pid_input               <= 16'h0000;
      pid_target_override     <= 1'b0;
    end else begin
      func_active  <= next_active;
      func_value   <= filtered; // [RL17]
      freq_command <= next_active[FN_MAIN_FREQ] ? freq_sat
                                                : 16'h0000; // [RL7]
      freq_reverse <= next_active[FN_MAIN_FREQ] &
                      (filtered < 0); // [RL8]
      lower_freq_limit <= next_active[FN_LOWER_LIM] ? pos_val
                                                    : 16'h0000; // [RL20]
      volt_bias_decivolt <= next_active[FN_VOLT_BIAS] ? vbias_val
                                                      : 16'h0000; // [RL19]
      accel_time_applied <= next_active[FN_RAMP_GAIN] ? ramp_val
                                            : first_accel_time; // [RL12]
      braking_current_applied <= next_active[FN_BRAKE_CUR] ? brake_min
                                    : programmed_braking_current; // [RL13]
      stall_level_applied <= next_active[FN_STALL_LVL] ? stall_min
                                             : run_stall_level; // [RL14]
      pid_input <= next_active[FN_PID_DIFF] ?
                   16'(pid_feedback_primary - filtered)
                   : pid_feedback_primary; // [RL16]
      pid_target_override <= next_active[FN_PID_TGT]; // [RL15]
    end
  end

  // Checks on the behaviour of the block.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // An accepted write of a legal code shows up in the setting.
  sequence s_func_write;
    wr_en && paddr == OFF_FUNCTION && wfunc_ok;
  endsequence
  a_func_write_lands: assert property (s_func_write |=> // [RL3]
    input_function_select == $past(wdata16[4:0]))
    else $error("function code write not stored");
  a_func_code_span: assert property (input_function_select <= 5'd19) // [RL3]
    else $error("function code out of span");
  a_gain_in_span: assert property ( // [RL6]
    input_gain_percent >= PCT_MIN && input_gain_percent <= PCT_MAX)
    else $error("gain setting outside span");
  a_freq_saturate: assert property (freq_command <= 16'd1000) // [RL7]
    else $error("frequency command above full scale");
  a_volt_no_neg: assert property (input_range_select != RANGE_4_20MA // [RL2]
    |-> sample >= 0)
    else $error("negative sample in a clamping range");
  a_freq_gate: assert property (freq_command != 16'h0000 |-> // [RL11]
    $past(fn == FN_MAIN_FREQ && analog_src))
    else $error("frequency command without analog source");
  a_ramp_shorten: assert property ( // [RL12]
    accel_time_applied <= $past(first_accel_time))
    else $error("ramp time lengthened");
  a_brake_min: assert property ( // [RL13]
    braking_current_applied <= $past(programmed_braking_current))
    else $error("braking current above programmed value");
  a_stall_min: assert property ( // [RL14]
    stall_level_applied <= $past(run_stall_level))
    else $error("stall level above programmed value");
  a_filter_pass: assert property (tick && input_filter_time == 8'h00 // [RL22]
    |=> filtered == $past(sample))
    else $error("zero filter time did not pass sample");
  a_filter_hold: assert property (!tick |=> $stable(filtered)) // [RL22]
    else $error("filter moved between updates");
  a_bus_answer: assert property (setup ##1 psel && penable // [RL18]
    |-> pready)
    else $error("no answer in access phase");

  // Writes keep the bias setting inside its legal span as well.
  a_bias_in_span: assert property ( // [RL6]
    input_bias_percent >= PCT_MIN && input_bias_percent <= PCT_MAX)
    else $error("bias setting outside span");
  // Filter time writes never exceed two seconds.
  a_filter_span: assert property ( // [RL9]
    input_filter_time <= FILTER_MAX[7:0])
    else $error("filter time outside span");
  // At most one function is routed at any time.
  a_route_onehot: assert property ($onehot0(func_active)) // [RL10]
    else $error("more than one function routed");
  // Reserved codes never light a function flag.
  a_reserved_dark: assert property ( // [RL10]
    func_active[1] == 1'b0 && func_active[17:12] == 6'h00)
    else $error("reserved function code routed");
  // The setpoint override needs PID control to be enabled.
  a_pid_target_gate: assert property ( // [RL15]
    pid_target_override |-> $past(pid_on && fn == FN_PID_TGT))
    else $error("PID target override without PID control");
  // Voltage bias is only applied in volts-per-hertz control.
  a_volt_bias_gate: assert property ( // [RL19]
    volt_bias_decivolt != 16'h0000 |->
    $past(vf_control_mode && fn == FN_VOLT_BIAS))
    else $error("voltage bias outside V/f control");
  // Torque level routing needs a torque detection selection.
  a_torque_gate: assert property ( // [RL17]
    func_active[FN_TORQUE] |-> $past(torque_on))
    else $error("torque level routed without detection");
  // The lower limit is only driven while code 2 is selected.
  a_lower_route: assert property ( // [RL20]
    lower_freq_limit != 16'h0000 |-> $past(fn == FN_LOWER_LIM))
    else $error("lower limit driven by another function");
endmodule : ain_scaling_router

//--- sim/analog_source.sv
// Behavioural model of the external analog voltage or current source.
`timescale 1ns/1ns
module analog_source (
  input  wire logic        pclk,
  input  wire logic        slow,
  input  wire logic [11:0] level,
  output logic      [11:0] code
);
  // The source starts at zero volts or zero current.
  initial code = 12'h000;
  // A prompt source jumps at once; a slow one slews 64 codes a cycle.
  always @(posedge pclk) begin
    if (!slow || (code > level ? code - level : level - code) <= 12'd64) begin
      code <= level;
    end else if (code < level) begin
      code <= code + 12'd64;
    end else begin
      code <= code - 12'd64;
    end
  end
endmodule : analog_source

//--- sim/ain_scaling_router_test.sv
// Self-checking bench for the analog input scaling and routing block.
`timescale 1ns/1ns
module ain_scaling_router_test;
  import ain_scaling_pkg::*;
  // One expected result: which output to look at and its value.
  typedef struct packed {logic [3:0] sel; logic [31:0] v;} note_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] level, code;
  logic [3:0]  src_a, src_b;
  logic [2:0]  pid_en, tq_sel;
  logic        vf, s400, freq_reverse, pid_target_override;
  logic [15:0] brake, stall, accel, fb, lfsr_s;
  logic [19:0] func_active;
  logic [15:0] func_value, freq_command, lower_freq_limit, volt_bias_decivolt;
  logic [15:0] accel_time_applied, braking_current_applied;
  logic [15:0] stall_level_applied, pid_input;
  note_t       notes[$];
  note_t       mon_n, mon_s;
  int          compares, miscompares;
  event        snap;
  // Clock of 40 ns period.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  ain_scaling_router #(.SAMPLE_PERIOD(4)) ain_scaling_router_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_analog_input(code),
    .primary_freq_source_select(src_a), .alternate_freq_source_select(src_b),
    .pid_enable_select(pid_en), .torque_detect_select_one(tq_sel),
    .vf_control_mode(vf), .supply_400v(s400),
    .programmed_braking_current(brake), .run_stall_level(stall),
    .first_accel_time(accel), .pid_feedback_primary(fb),
    .func_active(func_active), .func_value(func_value),
    .freq_command(freq_command), .freq_reverse(freq_reverse),
    .lower_freq_limit(lower_freq_limit),
    .volt_bias_decivolt(volt_bias_decivolt),
    .accel_time_applied(accel_time_applied),
    .braking_current_applied(braking_current_applied),
    .stall_level_applied(stall_level_applied), .pid_input(pid_input),
    .pid_target_override(pid_target_override));
  analog_source analog_source_inst (
    .pclk(pclk), .slow(slow), .level(level), .code(code));
  // Sixteen-bit shift register for the random feedback and accel time values.
  function logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Compares one seen value with its expectation and counts both outcomes.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // Picks the routed output named by a note.
  function logic [31:0] out_of(input logic [3:0] s);
    case (s)
      4'd2:    out_of = {12'h000, func_active};
      4'd3:    out_of = {16'h0000, func_value};
      4'd4:    out_of = {16'h0000, freq_command};
      4'd5:    out_of = {31'h0, freq_reverse};
      4'd6:    out_of = {16'h0000, lower_freq_limit};
      4'd7:    out_of = {16'h0000, volt_bias_decivolt};
      4'd8:    out_of = {16'h0000, accel_time_applied};
      4'd9:    out_of = {16'h0000, braking_current_applied};
      4'd10:   out_of = {16'h0000, stall_level_applied};
      4'd11:   out_of = {16'h0000, pid_input};
      default: out_of = {31'h0, pid_target_override};
    endcase
  endfunction : out_of
  // A completed read takes the oldest note: read data or the error flag.
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      mon_n = notes.pop_front();
      check(mon_n.sel == 4'd1 ? {31'h0, pslverr} : prdata, mon_n.v);
    end
  end
  // A snapshot request compares one routed output.
  always @(snap) begin
    mon_s = notes.pop_front();
    check(out_of(mon_s.sel), mon_s.v);
  end
  // One APB transfer; the request holds until pready is seen high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{4'd0, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Lets the filter strobe and the routing settle, then waits off the edge.
  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle
  task fn(input logic [4:0] c);
    wr(OFF_FUNCTION, {27'h0, c});
    settle(16);
  endtask : fn
  task look(input logic [3:0] s, input logic [31:0] e);
    notes.push_back('{s, e});
    ->snap;
    #1;
  endtask : look
  // Prints the counts and the verdict, then stops the run.
  task end_of_test;
    if (notes.size() != 0) begin
      miscompares++;
      $display("BAD %0t: %0d results never seen", $time, notes.size());
    end
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // Watchdog cuts a hang short.
  initial begin
    repeat (6000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    {psel, penable, pwrite, slow, vf, s400} = 6'b000011;
    {paddr, pwdata, level, presetn} = '0;
    {src_a, src_b, pid_en, tq_sel} = {4'h1, 4'h0, 3'h1, 3'h1};
    {brake, stall} = {16'd300, 16'd800};
    lfsr_s = lfsr(16'd45973);
    fb = {2'b00, lfsr_s[13:0]} + 16'd1000;
    lfsr_s = lfsr(lfsr_s);
    accel = {2'b00, lfsr_s[13:0]};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_RANGE, 32'h0000_0002);
    rd(OFF_FUNCTION, 32'h0000_0000);
    rd(OFF_GAIN, 32'h0000_03E8);
    rd(OFF_BIAS, 32'h0000_0000);
    rd(OFF_FILTER, 32'h0000_0005);
    notes.push_back('{4'd1, 32'h1});
    apb(1'b0, 8'h18, 32'h0);
    wr(OFF_GAIN, 32'h0000_7FFF);
    rd(OFF_GAIN, 32'h0000_270F);
    wr(OFF_BIAS, 32'hFFFF_8000);
    rd(OFF_BIAS, 32'h0000_D8FA);
    wr(OFF_FILTER, 32'h0000_012C);
    rd(OFF_FILTER, 32'h0000_00C8);
    wr(OFF_FUNCTION, 32'h0000_0014);
    rd(OFF_FUNCTION, 32'h0000_0000);
    wr(OFF_FILTER, 32'h0000_0000);
    wr(OFF_GAIN, 32'h0000_03E8);
    wr(OFF_BIAS, 32'h0000_0000);
    level <= 12'h800;
    fn(5'd2);
    look(4'd3, 32'd500);
    look(4'd6, 32'd500);
    look(4'd8, {16'h0, accel});
    look(4'd11, {16'h0, fb});
    wr(OFF_VALUE, 32'h0000_0000);
    rd(OFF_VALUE, 32'h0000_01F4);
    for (int c = 0; c < 20; c++) begin
      fn(c[4:0]);
      look(4'd2, (c == 1 || (c > 11 && c < 18)) ? 0 : 32'h1 << c);
    end
    fn(5'd4);
    look(4'd7, 32'd2000);
    @(posedge pclk);
    s400 <= 1'b0;
    settle(2);
    look(4'd7, 32'd1000);
    @(posedge pclk);
    vf <= 1'b0;
    settle(2);
    look(4'd7, 32'd0);
    fn(5'd5);
    look(4'd8, accel * 500 / 1000);
    fn(5'd6);
    look(4'd9, 32'd300);
    fn(5'd7);
    look(4'd10, 32'd500);
    fn(5'd9);
    look(4'd12, 32'd1);
    fn(5'd10);
    look(4'd11, {16'h0, fb - 16'd500});
    fn(5'd11);
    look(4'd3, 32'd500);
    wr(OFF_RANGE, 32'h0000_0001);
    wr(OFF_BIAS, 32'h0000_FF06);
    level <= CODE_4MA;
    fn(5'd0);
    look(4'd4, 32'd250);
    look(4'd5, 32'd1);
    @(posedge pclk);
    src_a <= 4'h2;
    settle(4);
    look(4'd4, 32'd0);
    wr(OFF_RANGE, 32'h0000_0000);
    src_b <= 4'h1;
    level <= 12'h199;
    settle(16);
    look(4'd4, 32'd0);
    look(4'd5, 32'd0);
    rd(OFF_VALUE, 32'h0000_0000);
    wr(OFF_RANGE, 32'h0000_0003);
    settle(16);
    rd(OFF_VALUE, 32'h0000_0000);
    wr(OFF_RANGE, 32'h0000_0002);
    wr(OFF_BIAS, 32'h0000_0000);
    wr(OFF_GAIN, 32'h0000_07D0);
    src_b <= 4'h1;
    slow <= 1'b1;
    level <= 12'hFFF;
    settle(90);
    look(4'd4, 32'd1000);
    rd(OFF_VALUE, 32'h0000_07CF);
    settle(1);
    end_of_test();
  end
endmodule : ain_scaling_router_test
